/* File: fwei_pkg.sv */
// Shared constants and state types for the flash write/erase interlock
`default_nettype none
package fwei_pkg;
   // Special register selects seen on the link
   localparam logic [7:0] SEL_KEY = 8'h01;
   localparam logic [7:0] SEL_PSC = 8'h02;
   localparam logic [7:0] SEL_SCALE = 8'h03;
   localparam logic [7:0] SEL_BANK = 8'h04;
   localparam logic [7:0] SEL_CACHE = 8'h05;
   // Key codes, in the order they must arrive
   localparam logic [7:0] KEY_FIRST_CODE = 8'hA5;
   localparam logic [7:0] KEY_SECOND_CODE = 8'hF1;
   // Field positions
   localparam int PSC_WE_BIT = 0;
   localparam int PSC_EE_BIT = 1;
   localparam int SCALE_EWT_BIT = 0;
   localparam int BANK_LSB = 0;
   localparam int CACHE_BLKW_BIT = 0;
   localparam int PAGE_LSB = 9;
   localparam int BANKED_BIT = 15;
   localparam logic [15:0] SHORT_LIMIT = 16'h00FF;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] REG_RESET = 8'h00;
   // Write and erase times
   localparam int CLK_MHZ = 25;
   localparam int WRITE_TIME_NS = 40000;
   localparam int ERASE_TIME_NS = 20000000;
   localparam int WRITE_CYC = (WRITE_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int ERASE_CYC = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 20;
   // Command port byte offsets
   localparam logic [4:0] OFS_SFR = 5'h00;
   localparam logic [4:0] OFS_ADDR = 5'h04;
   localparam logic [4:0] OFS_XWR = 5'h08;
   localparam logic [4:0] OFS_XRD = 5'h0C;
   localparam logic [4:0] OFS_CRD = 5'h10;
   localparam logic [4:0] OFS_STAT = 5'h14;
   localparam int ADDR_SHORT_BIT = 16;
   localparam int STAT_KEY_LSB = 8;
   localparam int STAT_STALL_BIT = 10;
   typedef enum logic [1:0] {
      KEY_LOCKED = 2'b00,
      KEY_FIRST = 2'b01,
      KEY_ARMED = 2'b11,
      KEY_DISABLED = 2'b10
   } fwei_key_t;
   typedef enum logic [1:0] {
      OP_IDLE = 2'b00,
      OP_ISSUE = 2'b01,
      OP_FETCH = 2'b11,
      OP_BUSY = 2'b10
   } fwei_op_t;
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_WAIT = 2'b01,
      H_DONE = 2'b11
   } fwei_host_t;
endpackage
`default_nettype wire

/* File: fwei_link_if.sv */
// Link between the CPU side and the flash interlock
`default_nettype none
interface fwei_link_if (input wire logic core_clk);
   logic sfr_wr;
   logic [7:0] sfr_sel;
   logic [7:0] sfr_data;
   logic xwr;
   logic xrd;
   logic crd;
   logic short_form;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   logic stall;
   logic [1:0] key_state;
   modport dev_mp (input sfr_wr, sfr_sel, sfr_data, xwr, xrd, crd, short_form, addr, wdata,
      output ack, rdata, stall, key_state);
   modport cpu_mp (output sfr_wr, sfr_sel, sfr_data, xwr, xrd, crd, short_form, addr, wdata,
      input ack, rdata, stall, key_state);
endinterface
`default_nettype wire

/* File: fwei_flash_ctl.sv */
// Flash write/erase sequencer with key interlock, device end of the link
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`default_nettype none
module fwei_flash_ctl #(
   parameter int ERASE_CYCLES = fwei_pkg::ERASE_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   fwei_link_if.dev_mp link,
   output logic flash_rd,
   output logic flash_prog,
   output logic flash_wide,
   output logic flash_erase,
   output logic [16:0] flash_addr,
   output logic [15:0] flash_wdata,
   input wire logic [15:0] flash_rdata,
   output logic dmem_rd,
   output logic dmem_wr,
   output logic [15:0] dmem_addr,
   output logic [7:0] dmem_wdata,
   input wire logic [7:0] dmem_rdata
);
   localparam logic [fwei_pkg::CNT_W-1:0] WRITE_LAST = fwei_pkg::CNT_W'(fwei_pkg::WRITE_CYC - 1);
   localparam logic [fwei_pkg::CNT_W-1:0] ERASE_LAST = fwei_pkg::CNT_W'(ERASE_CYCLES - 1);

   // Logical move address to physical flash address via bank select
   function automatic logic [16:0] fwei_phys(input logic [15:0] a, input logic [1:0] b);
      fwei_phys = a[fwei_pkg::BANKED_BIT] ? {b, a[14:0]} : {2'b00, a[14:0]};
   endfunction

   fwei_pkg::fwei_key_t key_st, next_key_st;
   fwei_pkg::fwei_op_t op_st, next_op_st;
   logic [7:0] psc, next_psc;
   logic [7:0] scale, next_scale;
   logic [7:0] bank, next_bank;
   logic [7:0] cch, next_cch;
   logic [fwei_pkg::CNT_W-1:0] cnt, next_cnt;
   logic prog_rd, next_prog_rd;
   logic pair, next_pair;
   logic cache_v, next_cache_v;
   logic [15:0] cache_addr, next_cache_addr;
   logic [7:0] cache_data, next_cache_data;
   logic [7:0] tgt_data, next_tgt_data;
   logic ack, next_ack;
   logic [7:0] rdata, next_rdata;
   logic stall, next_stall;
   logic next_flash_rd, next_flash_prog, next_flash_wide, next_flash_erase;
   logic [16:0] next_flash_addr;
   logic [15:0] next_flash_wdata;
   logic next_dmem_rd, next_dmem_wr;
   logic [15:0] next_dmem_addr;
   logic [7:0] next_dmem_wdata;
   logic we, ee, blkw;
   logic [1:0] bank_sel;
   logic [16:0] phys_addr;

   assign we = psc[fwei_pkg::PSC_WE_BIT];
   assign ee = psc[fwei_pkg::PSC_EE_BIT];
   assign blkw = cch[fwei_pkg::CACHE_BLKW_BIT];
   assign bank_sel = bank[fwei_pkg::BANK_LSB +: 2];
   // Physical target of the request; a function result cannot be part-selected directly
   assign phys_addr = fwei_phys(link.addr, bank_sel);

   // Next state of interlock, control registers and the operation engine
   always_comb
   begin
      next_key_st = key_st;
      next_op_st = op_st;
      next_psc = psc;
      next_scale = scale;
      next_bank = bank;
      next_cch = cch;
      next_cnt = cnt;
      next_prog_rd = prog_rd;
      next_pair = pair;
      next_cache_v = cache_v;
      next_cache_addr = cache_addr;
      next_cache_data = cache_data;
      next_tgt_data = tgt_data;
      next_ack = 1'b0;
      next_rdata = rdata;
      next_stall = stall;
      next_flash_rd = 1'b0;
      next_flash_prog = flash_prog;
      next_flash_wide = flash_wide;
      next_flash_erase = flash_erase;
      next_flash_addr = flash_addr;
      next_flash_wdata = flash_wdata;
      next_dmem_rd = 1'b0;
      next_dmem_wr = 1'b0;
      next_dmem_addr = dmem_addr;
      next_dmem_wdata = dmem_wdata;
      case (op_st)
         fwei_pkg::OP_IDLE:
         begin
            if (link.sfr_wr)
            begin
               next_ack = 1'b1;
               if (link.sfr_sel == fwei_pkg::SEL_KEY)
               begin
                  // Only order and value count, never the gap between keys
                  case (key_st)
                     fwei_pkg::KEY_LOCKED:
                        next_key_st = (link.sfr_data == fwei_pkg::KEY_FIRST_CODE) ?
                           fwei_pkg::KEY_FIRST : fwei_pkg::KEY_DISABLED;
                     fwei_pkg::KEY_FIRST:
                        next_key_st = (link.sfr_data == fwei_pkg::KEY_SECOND_CODE) ?
                           fwei_pkg::KEY_ARMED : fwei_pkg::KEY_DISABLED;
                     default:
                        next_key_st = fwei_pkg::KEY_DISABLED;
                  endcase
               end
               else if (link.sfr_sel == fwei_pkg::SEL_PSC)
                  next_psc = link.sfr_data;
               else if (link.sfr_sel == fwei_pkg::SEL_SCALE)
                  next_scale = link.sfr_data;
               else if (link.sfr_sel == fwei_pkg::SEL_BANK)
                  next_bank = link.sfr_data;
               else if (link.sfr_sel == fwei_pkg::SEL_CACHE)
                  next_cch = link.sfr_data;
            end
            else if (link.xwr && !we)
            begin
               next_dmem_wr = 1'b1;
               next_dmem_addr = link.addr;
               next_dmem_wdata = link.wdata;
               next_ack = 1'b1;
            end
            else if (link.xwr)
            begin
               next_ack = 1'b1;
               if (link.short_form && link.addr > fwei_pkg::SHORT_LIMIT)
                  next_ack = 1'b1;
               else if (key_st != fwei_pkg::KEY_ARMED)
                  next_key_st = fwei_pkg::KEY_DISABLED;
               else if (ee)
               begin
                  // Erase is timed; relock comes at its end
                  next_ack = 1'b0;
                  next_flash_erase = 1'b1;
                  next_flash_addr = {phys_addr[16:fwei_pkg::PAGE_LSB],
                     {fwei_pkg::PAGE_LSB{1'b0}}};
                  next_cnt = ERASE_LAST;
                  next_stall = 1'b1;
                  next_cache_v = 1'b0;
                  next_op_st = fwei_pkg::OP_BUSY;
               end
               else if (blkw && (!cache_v || link.addr != cache_addr + 16'h0001))
               begin
                  // First byte only waits in the cache; it is lost if no partner comes
                  next_cache_v = 1'b1;
                  next_cache_addr = link.addr;
                  next_cache_data = link.wdata;
                  next_key_st = fwei_pkg::KEY_LOCKED;
               end
               else
               begin
                  // Fetch old contents first so programming can only clear bits
                  next_ack = 1'b0;
                  next_pair = blkw;
                  next_prog_rd = 1'b1;
                  next_tgt_data = link.wdata;
                  next_flash_rd = 1'b1;
                  next_flash_addr = fwei_phys(blkw ? cache_addr : link.addr, bank_sel);
                  next_cache_v = 1'b0;
                  next_stall = 1'b1;
                  next_op_st = fwei_pkg::OP_ISSUE;
               end
            end
            else if (link.xrd)
            begin
               next_dmem_rd = 1'b1;
               next_dmem_addr = link.addr;
               next_prog_rd = 1'b0;
               next_pair = 1'b0;
               next_op_st = fwei_pkg::OP_ISSUE;
            end
            else if (link.crd)
            begin
               next_flash_rd = 1'b1;
               next_flash_addr = phys_addr;
               next_prog_rd = 1'b0;
               next_pair = 1'b1;
               next_op_st = fwei_pkg::OP_ISSUE;
            end
         end
         fwei_pkg::OP_ISSUE:
            next_op_st = fwei_pkg::OP_FETCH;
         fwei_pkg::OP_FETCH:
         begin
            if (!prog_rd)
            begin
               // pair marks a code read here, taken from flash
               next_rdata = pair ? flash_rdata[7:0] : dmem_rdata;
               next_ack = 1'b1;
               next_op_st = fwei_pkg::OP_IDLE;
            end
            else
            begin
               next_flash_prog = 1'b1;
               next_flash_wide = pair;
               if (pair)
                  next_flash_wdata = {flash_rdata[15:8] & tgt_data,
                     flash_rdata[7:0] & cache_data};
               else
                  next_flash_wdata = {fwei_pkg::ERASED_BYTE,
                     flash_rdata[7:0] & tgt_data};
               next_cnt = WRITE_LAST;
               next_op_st = fwei_pkg::OP_BUSY;
            end
         end
         default:
         begin
            if (cnt == '0)
            begin
               next_flash_prog = 1'b0;
               next_flash_wide = 1'b0;
               next_flash_erase = 1'b0;
               next_stall = 1'b0;
               next_ack = 1'b1;
               next_key_st = fwei_pkg::KEY_LOCKED;
               next_op_st = fwei_pkg::OP_IDLE;
            end
            else
               next_cnt = cnt - 1'b1;
         end
      endcase
      // Disabled is sticky whatever path ran above
      if (key_st == fwei_pkg::KEY_DISABLED)
         next_key_st = fwei_pkg::KEY_DISABLED;
   end

   // Register everything; only reset clears the disabled state
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         key_st <= fwei_pkg::KEY_LOCKED;
         op_st <= fwei_pkg::OP_IDLE;
         psc <= fwei_pkg::REG_RESET;
         scale <= fwei_pkg::REG_RESET;
         bank <= fwei_pkg::REG_RESET;
         cch <= fwei_pkg::REG_RESET;
         cnt <= '0;
         prog_rd <= 1'b0;
         pair <= 1'b0;
         cache_v <= 1'b0;
         cache_addr <= 16'h0000;
         cache_data <= 8'h00;
         tgt_data <= 8'h00;
         ack <= 1'b0;
         rdata <= 8'h00;
         stall <= 1'b0;
         flash_rd <= 1'b0;
         flash_prog <= 1'b0;
         flash_wide <= 1'b0;
         flash_erase <= 1'b0;
         flash_addr <= 17'h00000;
         flash_wdata <= 16'h0000;
         dmem_rd <= 1'b0;
         dmem_wr <= 1'b0;
         dmem_addr <= 16'h0000;
         dmem_wdata <= 8'h00;
      end
      else
      begin
         key_st <= next_key_st;
         op_st <= next_op_st;
         psc <= next_psc;
         scale <= next_scale;
         bank <= next_bank;
         cch <= next_cch;
         cnt <= next_cnt;
         prog_rd <= next_prog_rd;
         pair <= next_pair;
         cache_v <= next_cache_v;
         cache_addr <= next_cache_addr;
         cache_data <= next_cache_data;
         tgt_data <= next_tgt_data;
         ack <= next_ack;
         rdata <= next_rdata;
         stall <= next_stall;
         flash_rd <= next_flash_rd;
         flash_prog <= next_flash_prog;
         flash_wide <= next_flash_wide;
         flash_erase <= next_flash_erase;
         flash_addr <= next_flash_addr;
         flash_wdata <= next_flash_wdata;
         dmem_rd <= next_dmem_rd;
         dmem_wr <= next_dmem_wr;
         dmem_addr <= next_dmem_addr;
         dmem_wdata <= next_dmem_wdata;
      end
   end

   // Link answers straight from flops
   assign link.ack = ack;
   assign link.rdata = rdata;
   assign link.stall = stall;
   assign link.key_state = key_st;
endmodule
`default_nettype wire

/* File: fwei_cpu_port.sv */
// CPU-side end: Avalon-MM command port driving the flash interlock link
`default_nettype none
module fwei_cpu_port (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   fwei_link_if.cpu_mp link
);
   fwei_pkg::fwei_host_t st, next_st;
   logic wait_q, next_wait_q;
   logic [31:0] rd_q, next_rd_q;
   logic [15:0] addr_q, next_addr_q;
   logic short_q, next_short_q;
   logic [7:0] last_q, next_last_q;
   logic sfr_wr_q, next_sfr_wr_q;
   logic xwr_q, next_xwr_q;
   logic xrd_q, next_xrd_q;
   logic crd_q, next_crd_q;
   logic [7:0] sel_q, next_sel_q;
   logic [7:0] dat_q, next_dat_q;

   // Commands wait for the link answer; local accesses answer at once
   always_comb
   begin
      next_st = st;
      next_wait_q = 1'b1;
      next_rd_q = rd_q;
      next_addr_q = addr_q;
      next_short_q = short_q;
      next_last_q = last_q;
      next_sfr_wr_q = 1'b0;
      next_xwr_q = 1'b0;
      next_xrd_q = 1'b0;
      next_crd_q = 1'b0;
      next_sel_q = sel_q;
      next_dat_q = dat_q;
      case (st)
         fwei_pkg::H_IDLE:
         begin
            if (avs_write && avs_address == fwei_pkg::OFS_SFR)
            begin
               next_sfr_wr_q = 1'b1;
               next_sel_q = avs_writedata[15:8];
               next_dat_q = avs_writedata[7:0];
               next_st = fwei_pkg::H_WAIT;
            end
            else if (avs_write && avs_address == fwei_pkg::OFS_XWR)
            begin
               next_xwr_q = 1'b1;
               next_dat_q = avs_writedata[7:0];
               next_st = fwei_pkg::H_WAIT;
            end
            else if (avs_write && avs_address == fwei_pkg::OFS_XRD)
            begin
               next_xrd_q = 1'b1;
               next_st = fwei_pkg::H_WAIT;
            end
            else if (avs_write && avs_address == fwei_pkg::OFS_CRD)
            begin
               next_crd_q = 1'b1;
               next_st = fwei_pkg::H_WAIT;
            end
            else if (avs_write || avs_read)
            begin
               if (avs_write && avs_address == fwei_pkg::OFS_ADDR)
               begin
                  next_addr_q = avs_writedata[15:0];
                  next_short_q = avs_writedata[fwei_pkg::ADDR_SHORT_BIT];
               end
               next_rd_q = 32'h00000000;
               if (avs_read && avs_address == fwei_pkg::OFS_ADDR)
                  next_rd_q = {15'h0000, short_q, addr_q};
               else if (avs_read && avs_address == fwei_pkg::OFS_STAT)
                  next_rd_q = {21'h000000, link.stall, link.key_state, last_q};
               next_wait_q = 1'b0;
               next_st = fwei_pkg::H_DONE;
            end
         end
         fwei_pkg::H_WAIT:
         begin
            // Stays here through any stalled flash operation
            if (link.ack)
            begin
               next_last_q = link.rdata;
               next_wait_q = 1'b0;
               next_st = fwei_pkg::H_DONE;
            end
         end
         default:
            next_st = fwei_pkg::H_IDLE;
      endcase
   end

   // Register the port state
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         st <= fwei_pkg::H_IDLE;
         wait_q <= 1'b1;
         rd_q <= 32'h00000000;
         addr_q <= 16'h0000;
         short_q <= 1'b0;
         last_q <= 8'h00;
         sfr_wr_q <= 1'b0;
         xwr_q <= 1'b0;
         xrd_q <= 1'b0;
         crd_q <= 1'b0;
         sel_q <= 8'h00;
         dat_q <= 8'h00;
      end
      else
      begin
         st <= next_st;
         wait_q <= next_wait_q;
         rd_q <= next_rd_q;
         addr_q <= next_addr_q;
         short_q <= next_short_q;
         last_q <= next_last_q;
         sfr_wr_q <= next_sfr_wr_q;
         xwr_q <= next_xwr_q;
         xrd_q <= next_xrd_q;
         crd_q <= next_crd_q;
         sel_q <= next_sel_q;
         dat_q <= next_dat_q;
      end
   end

   assign avs_waitrequest = wait_q;
   assign avs_readdata = rd_q;
   assign link.sfr_wr = sfr_wr_q;
   assign link.xwr = xwr_q;
   assign link.xrd = xrd_q;
   assign link.crd = crd_q;
   assign link.sfr_sel = sel_q;
   assign link.sfr_data = dat_q;
   assign link.wdata = dat_q;
   assign link.addr = addr_q;
   assign link.short_form = short_q;
endmodule
`default_nettype wire

/* File: fwei_link_assertions.sv */
// Concurrent checks on the link between the CPU port and the flash sequencer
`default_nettype none
module fwei_link_assertions (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_sel,
   input wire logic [7:0] sfr_data,
   input wire logic xwr,
   input wire logic short_form,
   input wire logic [15:0] addr,
   input wire logic ack,
   input wire logic stall,
   input wire logic [1:0] key_state
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   logic kw;
   logic [10:0] scnt;
   logic [10:0] next_scnt;
   // Key register writes
   assign kw = sfr_wr && (sfr_sel == fwei_pkg::SEL_KEY);
   // Stall length; a stall that never ends would otherwise pass silently
   always_comb next_scnt = (stall && rst_n) ? scnt + 11'h001 : 11'h000;
   always_ff @(posedge core_clk) scnt <= next_scnt;

   chk_key_first: assert property (kw && sfr_data == fwei_pkg::KEY_FIRST_CODE &&
      key_state == 2'h0 |-> ##[1:2] key_state == 2'h1) else $error("first key not taken");
   chk_key_arm: assert property (kw && sfr_data == fwei_pkg::KEY_SECOND_CODE &&
      key_state == 2'h1 |-> ##[1:2] key_state == 2'h3) else $error("second key not taken");
   chk_key_reject: assert property (kw && (key_state == 2'h3 ||
      (key_state == 2'h0 && sfr_data != fwei_pkg::KEY_FIRST_CODE) ||
      (key_state == 2'h1 && sfr_data != fwei_pkg::KEY_SECOND_CODE))
      |-> ##[1:2] key_state == 2'h2) else $error("bad key did not disable");
   chk_dis_sticky: assert property (key_state == 2'h2 |=> key_state == 2'h2)
      else $error("disabled state left without reset");
   chk_armed_hold: assert property (key_state == 2'h3 && !sfr_wr && !xwr && !stall && !ack
      |=> key_state == 2'h3) else $error("armed state lost while idle");
   chk_stall_ack: assert property ($fell(stall) |-> ack)
      else $error("stall ended without ack");
   chk_op_relock: assert property ($fell(stall) |-> key_state == 2'h0)
      else $error("no relock after operation");
   chk_stall_bound: assert property (scnt <= 11'h44C)
      else $error("stall too long");
   chk_short_skip: assert property (xwr && short_form && addr > fwei_pkg::SHORT_LIMIT
      |=> (ack && !stall && key_state == $past(key_state)) ##1 !stall)
      else $error("short form write above limit acted");

   cover property ($fell(stall));
   cover property (key_state == 2'h2);
   cover property (kw && key_state == 2'h1);
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench: CPU port and flash sequencer joined over the link
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic flash_rd, flash_prog, flash_wide, flash_erase, dmem_rd, dmem_wr;
   logic [16:0] flash_addr;
   logic [15:0] flash_wdata, dmem_addr;
   logic [15:0] flash_rdata = 16'hFFFF;
   logic [7:0] dmem_wdata;
   logic [7:0] dmem_rdata = 8'h00;
   logic [7:0] fmem [0:131071];
   logic [7:0] xmem [0:65535];
   logic [10:0] expq [$];
   logic [10:0] exp_v;
   logic [7:0] d1, d2;
   int mismatches = 0;
   int n_compared = 0;
   int seed = 43222;

   // 25 MHz system clock
   always #20 core_clk = ~core_clk;

   fwei_link_if link (.core_clk);
   fwei_cpu_port fwei_cpu_port_inst (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .link);
   fwei_flash_ctl #(.ERASE_CYCLES(20)) fwei_flash_ctl_inst (.core_clk, .rst_n, .link, .flash_rd,
      .flash_prog, .flash_wide, .flash_erase, .flash_addr, .flash_wdata, .flash_rdata, .dmem_rd,
      .dmem_wr, .dmem_addr, .dmem_wdata, .dmem_rdata);
   fwei_link_assertions fwei_link_assertions_inst (.core_clk, .rst_n, .sfr_wr(link.sfr_wr),
      .sfr_sel(link.sfr_sel), .sfr_data(link.sfr_data), .xwr(link.xwr), .ack(link.ack),
      .short_form(link.short_form), .addr(link.addr), .stall(link.stall),
      .key_state(link.key_state));

   // Flash macro and data RAM stand-ins; programming repeats while the strobe stands
   always @(posedge core_clk)
   begin
      if (flash_rd)
         flash_rdata <= {fmem[flash_addr + 17'h00001], fmem[flash_addr]};
      if (flash_prog)
         fmem[flash_addr] <= flash_wdata[7:0];
      if (flash_prog && flash_wide)
         fmem[flash_addr + 17'h00001] <= flash_wdata[15:8];
      if (flash_erase)
         for (int i = 0; i < 512; i++)
            fmem[{flash_addr[16:9], 9'h000} + 17'(i)] <= 8'hFF;
      if (dmem_wr)
         xmem[dmem_addr] <= dmem_wdata;
      if (dmem_rd)
         dmem_rdata <= xmem[dmem_addr];
   end

   // Read answers are compared in order with the notes left by the driver
   always @(posedge core_clk)
      if (avs_read && avs_waitrequest === 1'b0)
      begin
         exp_v = (expq.size() > 0) ? expq.pop_front() : 11'h7FF;
         n_compared++;
         if (avs_readdata[10:0] !== exp_v)
         begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, avs_readdata[10:0], exp_v);
         end
      end

   task automatic tally_and_finish;
      $display("compared=%0d mismatches=%0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic [4:0] a, input logic [31:0] d, input logic rd);
      int n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 2000);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0)
      begin
         mismatches++;
         $display("[ERR] t=%0t bus timeout addr=%h", $time, a);
         tally_and_finish();
      end
   endtask

   task automatic sfr(input logic [7:0] sel, input logic [7:0] v);
      bus(fwei_pkg::OFS_SFR, {16'h0000, sel, v}, 1'b0);
   endtask

   task automatic keys;
      sfr(fwei_pkg::SEL_KEY, fwei_pkg::KEY_FIRST_CODE);
      sfr(fwei_pkg::SEL_KEY, fwei_pkg::KEY_SECOND_CODE);
   endtask

   // Data move write, with the short-form flag
   task automatic xw(input logic [15:0] a, input logic [7:0] v, input logic sf);
      bus(fwei_pkg::OFS_ADDR, {15'h0000, sf, a}, 1'b0);
      bus(fwei_pkg::OFS_XWR, {24'h000000, v}, 1'b0);
   endtask

   // Status read; expects interlock state, no stall, and the last byte read
   task automatic stat(input logic [1:0] k, input logic [7:0] b);
      expq.push_back({1'b0, k, b});
      bus(fwei_pkg::OFS_STAT, 32'h00000000, 1'b1);
   endtask

   // Code read (c high) or data move read (c low) of one byte, then status check
   task automatic rdx(input logic [15:0] a, input logic [1:0] k, input logic [7:0] b,
      input logic c);
      bus(fwei_pkg::OFS_ADDR, {16'h0000, a}, 1'b0);
      bus(c ? fwei_pkg::OFS_CRD : fwei_pkg::OFS_XRD, 32'h00000000, 1'b0);
      stat(k, b);
   endtask

   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
   endtask

   initial
   begin
      for (int i = 0; i < 131072; i++) fmem[i] = 8'hFF;
      for (int i = 0; i < 65536; i++) xmem[i] = 8'h00;
      fmem[17'h001FF] = 8'h00;
      fmem[17'h00300] = 8'h00;
      fmem[17'h00400] = 8'h00;
      xmem[16'h0234] = 8'h3C;
      d1 = 8'($random(seed));
      d2 = 8'($random(seed));
      do_reset();
      stat(2'h0, 8'h00);
      sfr(fwei_pkg::SEL_KEY, fwei_pkg::KEY_FIRST_CODE);
      repeat (37) @(posedge core_clk);
      stat(2'h1, 8'h00);
      sfr(fwei_pkg::SEL_KEY, fwei_pkg::KEY_SECOND_CODE);
      stat(2'h3, 8'h00);
      sfr(fwei_pkg::SEL_PSC, 8'h03);
      xw(16'h0300, 8'h00, 1'b1);
      rdx(16'h0300, 2'h3, 8'h00, 1'b1);
      $display("test arm done");
      sfr(fwei_pkg::SEL_BANK, 8'h00);
      sfr(fwei_pkg::SEL_SCALE, 8'h01);
      xw(16'h0234, 8'h5A, 1'b0);
      rdx(16'h0300, 2'h0, 8'hFF, 1'b1);
      rdx(16'h0400, 2'h0, 8'h00, 1'b1);
      rdx(16'h01FF, 2'h0, 8'h00, 1'b1);
      $display("test erase done");
      sfr(fwei_pkg::SEL_PSC, 8'h01);
      keys();
      xw(16'h0234, d1, 1'b0);
      rdx(16'h0234, 2'h0, d1, 1'b1);
      keys();
      xw(16'h0234, d2, 1'b0);
      rdx(16'h0234, 2'h0, d1 & d2, 1'b1);
      rdx(16'h0234, 2'h0, 8'h3C, 1'b0);
      $display("test program done");
      sfr(fwei_pkg::SEL_CACHE, 8'h01);
      keys();
      xw(16'h0240, d1, 1'b0);
      rdx(16'h0240, 2'h0, 8'hFF, 1'b1);
      keys();
      xw(16'h0241, d2, 1'b0);
      rdx(16'h0240, 2'h0, d1, 1'b1);
      rdx(16'h0241, 2'h0, d2, 1'b1);
      keys();
      xw(16'h0250, 8'h33, 1'b0);
      sfr(fwei_pkg::SEL_CACHE, 8'h00);
      rdx(16'h0250, 2'h0, 8'hFF, 1'b1);
      $display("test block done");
      sfr(fwei_pkg::SEL_PSC, 8'h00);
      xw(16'h0260, 8'h77, 1'b0);
      rdx(16'h0260, 2'h0, 8'h77, 1'b0);
      rdx(16'h0260, 2'h0, 8'hFF, 1'b1);
      $display("test steer done");
      sfr(fwei_pkg::SEL_PSC, 8'h01);
      xw(16'h0270, 8'h00, 1'b0);
      stat(2'h2, 8'hFF);
      keys();
      xw(16'h0270, 8'h00, 1'b0);
      rdx(16'h0270, 2'h2, 8'hFF, 1'b1);
      do_reset();
      stat(2'h0, 8'h00);
      sfr(fwei_pkg::SEL_KEY, fwei_pkg::KEY_SECOND_CODE);
      stat(2'h2, 8'h00);
      do_reset();
      sfr(fwei_pkg::SEL_KEY, 8'h5A);
      keys();
      sfr(fwei_pkg::SEL_PSC, 8'h01);
      xw(16'h0280, 8'h00, 1'b0);
      rdx(16'h0280, 2'h2, 8'hFF, 1'b1);
      $display("test lockout done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
